// *** core/wake_clk_ctrl.sv ***
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "wake_clk_map.svh"
// Functional notes
// RULE1 - fast wake runs system from sub clock
// RULE2 - fast wake only from SLEEP1 or IDLE0
// RULE3 - fast wake ignored waking from SLEEP0
// RULE4 - fast_wake_enable bit enables fast wake
// RULE5 - crystal fast wake resumes within 1~2 sub ticks
// RULE6 - after 128 crystal cycles set ready, switch
// RULE7 - RC wake: 15~16 high or 1~2 low
// RULE8 - RC system oscillator ignores fast_wake_enable
// RULE9 - watchdog off: no fast wake from SLEEP0
// RULE10 - mode bits switch speed; halt enters power-down
// RULE11 - halt picks IDLE/SLEEP and IDLE variant
// RULE12 - moving to sub clock stops high oscillator
// RULE13 - software clears select, divider 000/001 for slow
// RULE14 - slow from option oscillator; software checks ready
// RULE15 - software sets select or divider 010-111
// RULE16 - returning fast waits oscillator stabilisation time
// RULE17 - divider codes select sub or high divisions
// RULE18 - low ready after 128 or 1~2 cycles
// RULE19 - IDLE keeps system clock only if keep set
// RULE20 - source changeovers happen on clean tick boundaries
module wake_clk_ctrl
  import wake_clk_pkg::*;
#(
  parameter int HIGH_XTAL_CYCLES = `HIGH_XTAL_CYCLES,
  parameter int HIGH_RC_CYCLES = `HIGH_RC_CYCLES,
  parameter int LOW_XTAL_CYCLES = `LOW_XTAL_CYCLES,
  parameter int LOW_RC_CYCLES = `LOW_RC_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic high_osc_tick,
  input wire logic sub_osc_tick,
  input wire logic high_is_crystal,
  input wire logic low_is_crystal,
  input wire logic watchdog_enable,
  input wire logic lvd_enable,
  input wire logic halt_exec,
  input wire logic wake_event,
  output logic sys_tick,
  output logic cpu_run,
  output logic high_osc_run,
  output logic sub_osc_run,
  output logic div16_tick,
  output logic div64_tick
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (HIGH_XTAL_CYCLES < 1 || HIGH_XTAL_CYCLES > 255 || HIGH_RC_CYCLES < 1 || HIGH_RC_CYCLES > 255 ||
      LOW_XTAL_CYCLES < 1 || LOW_XTAL_CYCLES > 255 || LOW_RC_CYCLES < 1 || LOW_RC_CYCLES > 255)
  begin : g_bad_count
    $error("stabilisation counts must lie in 1..255");
  end

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic logic [1:0] reg_index(input logic [7:0] addr);
    unique case (addr)
      `CLK_MODE_OFFSET: reg_index = 2'd0;
      `CTRL_OFFSET: reg_index = 2'd1;
      `STATUS_OFFSET: reg_index = 2'd2;
      default: reg_index = 2'd3;
    endcase
  endfunction

  // mask of low divider bits that must all be set for one divided tick
  function automatic logic [5:0] div_mask(input logic [2:0] cks);
    unique case (cks)
      3'b010: div_mask = 6'h3f;
      3'b011: div_mask = 6'h1f;
      3'b100: div_mask = 6'h0f;
      3'b101: div_mask = 6'h07;
      3'b110: div_mask = 6'h03;
      3'b111: div_mask = 6'h01;
      default: div_mask = 6'h00;
    endcase
  endfunction

  state_t s;
  state_t next_s;
  logic want_high;
  logic halted;
  logic run;
  logic high_div_tick;
  logic src_tick;
  logic src_ready;
  logic [7:0] hlimit;
  logic [7:0] llimit;
  logic [7:0] mode_byte;

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign sys_tick = s.sys_tick;
  assign cpu_run = s.cpu_run;
  assign high_osc_run = s.high_run;
  // sub clock stops only in SLEEP0, which halt picks when idle is off and watchdog and lvd are both off
  assign sub_osc_run = s.state != st_sleep0;
  assign div16_tick = s.div16_tick;
  assign div64_tick = s.div64_tick;

  always_comb
  begin
    next_s = s;
    // RULE17 divider decode
    want_high = s.high_clock_select || (s.cks[2:1] != 2'b00);
    run = (s.state == st_run_fast) || (s.state == st_run_slow);
    halted = (s.state == st_idle0) || (s.state == st_idle1) || (s.state == st_sleep0) || (s.state == st_sleep1);
    high_div_tick = high_osc_tick && (s.high_clock_select || ((s.div_cnt & div_mask(s.cks)) == div_mask(s.cks)));
    src_tick = s.src_high ? high_div_tick : sub_osc_tick;
    src_ready = s.src_high ? s.high_osc_ready_flag : s.low_osc_ready_flag;
    hlimit = high_is_crystal ? 8'(HIGH_XTAL_CYCLES - 1) : 8'(HIGH_RC_CYCLES - 1);
    llimit = low_is_crystal ? 8'(LOW_XTAL_CYCLES - 1) : 8'(LOW_RC_CYCLES - 1);
    mode_byte = {s.cks, s.fast_wake_enable, s.low_osc_ready_flag, s.high_osc_ready_flag, s.idle_on_halt_enable, s.high_clock_select};

    // ----------------------------------------
    // oscillator ready counters
    // ----------------------------------------
    // RULE16 high ready after its stabilisation count
    if (!s.high_run)
    begin
      next_s.high_osc_ready_flag = 1'b0;
      next_s.hcnt = 8'h00;
    end
    else if (!s.high_osc_ready_flag && high_osc_tick)
    begin
      next_s.hcnt = s.hcnt + 8'h01;
      next_s.high_osc_ready_flag = s.hcnt == hlimit;
    end
    // RULE18 low ready count restarts whenever the sub clock stopped
    if (s.state == st_sleep0)
    begin
      next_s.low_osc_ready_flag = 1'b0;
      next_s.lcnt = 8'h00;
    end
    else if (!s.low_osc_ready_flag && sub_osc_tick)
    begin
      next_s.lcnt = s.lcnt + 8'h01;
      next_s.low_osc_ready_flag = s.lcnt == llimit;
    end
    if (high_osc_tick && s.high_run)
      next_s.div_cnt = s.div_cnt + 6'h01;

    // ----------------------------------------
    // power mode sequencing
    // ----------------------------------------
    next_s.sys_tick = 1'b0;
    next_s.cpu_run = 1'b0;
    unique case (s.state)
      st_run_fast, st_run_slow:
      begin
        next_s.cpu_run = 1'b1;
        next_s.sys_tick = src_tick;
        // RULE10 halt is the only way into power-down
        if (halt_exec)
        begin
          next_s.cpu_run = 1'b0;
          // RULE11 idle vs sleep, then idle variant
          if (s.idle_on_halt_enable)
            next_s.state = s.idle_sysclk_keep ? st_idle1 : st_idle0;
          // RULE9 no sub clock means SLEEP0
          else
            next_s.state = (watchdog_enable || lvd_enable) ? st_sleep1 : st_sleep0;
          if (!(s.idle_on_halt_enable && s.idle_sysclk_keep))
            next_s.high_run = 1'b0;
        end
        // RULE20 change source only on the new source's own tick
        else if (s.src_high && !want_high && sub_osc_tick)
        begin
          // RULE12 high oscillator and its divided ticks stop
          next_s.src_high = 1'b0;
          next_s.high_run = 1'b0;
          next_s.state = st_run_slow;
        end
        else if (!s.src_high && want_high)
        begin
          // RULE16 switch only once high oscillator is stable
          next_s.high_run = 1'b1;
          if (s.high_osc_ready_flag && high_osc_tick)
          begin
            next_s.src_high = 1'b1;
            next_s.state = st_run_fast;
          end
        end
      end
      st_idle1:
      begin
        // RULE19 peripherals keep the system clock
        next_s.sys_tick = src_tick;
        if (wake_event)
          next_s.state = st_wake;
      end
      st_idle0, st_sleep0, st_sleep1:
      begin
        if (wake_event)
        begin
          next_s.high_run = s.src_high;
          // RULE2 RULE3 RULE4 RULE8 fast wake only crystal, enabled, sub running
          if (s.src_high && high_is_crystal && s.fast_wake_enable && s.state != st_sleep0)
            next_s.state = st_fast_wake;
          else
            next_s.state = st_wake;
        end
      end
      st_wake:
      begin
        // RULE7 resume after the source's ready count
        if (src_ready && src_tick)
        begin
          next_s.state = s.src_high ? st_run_fast : st_run_slow;
          next_s.cpu_run = 1'b1;
          next_s.sys_tick = 1'b1;
        end
      end
      st_fast_wake:
      begin
        // RULE1 RULE5 run from sub clock at its first tick
        next_s.cpu_run = 1'b1;
        next_s.sys_tick = sub_osc_tick;
        // RULE6 RULE20 hand over on a high tick once ready
        if (s.high_osc_ready_flag && high_osc_tick)
        begin
          next_s.state = st_run_fast;
          next_s.sys_tick = high_div_tick;
        end
      end
    endcase
    next_s.div16_tick = s.high_run && high_osc_tick && (s.div_cnt[3:0] == 4'hf);
    next_s.div64_tick = s.high_run && high_osc_tick && (s.div_cnt == 6'h3f);

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    if (s_axi_awvalid && s.awready)
    begin
      next_s.awready = 1'b0;
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.wready = 1'b0;
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RESP_OKAY;
      unique case (reg_index(s.awaddr))
        2'd0:
          if (s.wstrb[0])
          begin
            // RULE13 RULE15 software picks the mode through these fields
            next_s.cks = s.wdata[`CKS_MSB:`CKS_LSB];
            next_s.fast_wake_enable = s.wdata[`FAST_WAKE_ENABLE_BIT];
            next_s.idle_on_halt_enable = s.wdata[`IDLE_ON_HALT_ENABLE_BIT];
            next_s.high_clock_select = s.wdata[`HIGH_CLOCK_SELECT_BIT];
          end
        2'd1:
          if (s.wstrb[0])
            next_s.idle_sysclk_keep = s.wdata[`IDLE_SYSCLK_KEEP_BIT];
        // status writes are accepted and ignored
        2'd2: next_s.bresp = `RESP_OKAY;
        default: next_s.bresp = `RESP_SLVERR;
      endcase
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (s_axi_arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = `RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      unique case (reg_index(s_axi_araddr))
        // RULE14 ready flags visible to software
        2'd0: next_s.rdata = {24'h00_0000, mode_byte};
        2'd1: next_s.rdata = {24'h00_0000, s.idle_sysclk_keep, 7'h00};
        2'd2: next_s.rdata = {21'h00_0000, s.state != st_sleep0, s.high_run, s.src_high, s.state};
        default: next_s.rresp = `RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.state <= st_run_fast;
      s.src_high <= 1'b1;
      s.high_run <= 1'b1;
      {s.cks, s.fast_wake_enable} <= 4'h0;
      s.idle_on_halt_enable <= 1'(`CLK_MODE_RESET >> `IDLE_ON_HALT_ENABLE_BIT);
      s.high_clock_select <= 1'(`CLK_MODE_RESET >> `HIGH_CLOCK_SELECT_BIT);
      s.idle_sysclk_keep <= 1'(`CTRL_RESET >> `IDLE_SYSCLK_KEEP_BIT);
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_halt_idle1;
    run && halt_exec && s.idle_on_halt_enable && s.idle_sysclk_keep;
  endsequence
  sequence seq_fast_wake_tick;
    (s.state == st_fast_wake) && sub_osc_tick && !(s.high_osc_ready_flag && high_osc_tick);
  endsequence

  a_halt_idle_pick: assert property (seq_halt_idle1 |=> s.state == st_idle1) // RULE11
    else $error("halt with idle and keep set did not enter IDLE1");
  a_halt_only_entry: assert property ($rose(halted) |-> $past(halt_exec) && $past(run)) // RULE10
    else $error("power-down entered without halt");
  a_sleep0_no_fast: assert property ((s.state == st_sleep0) && wake_event |=> s.state == st_wake) // RULE3
    else $error("fast wake taken from SLEEP0");
  a_rc_ignores_fast: assert property (halted && wake_event && !high_is_crystal |=> s.state != st_fast_wake) // RULE8
    else $error("fast wake taken with RC system oscillator");
  a_fast_wake_run: assert property (seq_fast_wake_tick |=> cpu_run && sys_tick) // RULE5
    else $error("fast wake did not run from sub tick");
  a_high_stop: assert property ($fell(s.src_high) |-> !high_osc_run ##1 !div16_tick && !div64_tick) // RULE12
    else $error("high oscillator kept running on sub clock");
  a_fast_wake_exit: assert property ((s.state == st_fast_wake) ##1 (s.state == st_run_fast) |-> s.high_osc_ready_flag) // RULE6
    else $error("fast wake ended before high oscillator ready");
  a_idle0_stop: assert property ((s.state == st_idle0) && $past(s.state == st_idle0) |-> !sys_tick) // RULE19
    else $error("system tick running in IDLE0");
  a_low_ready: assert property ($rose(s.low_osc_ready_flag) |-> $past(s.lcnt) == $past(llimit)) // RULE18
    else $error("low ready flag rose early");
  a_divider_full: assert property (run && s.src_high && s.high_clock_select && high_osc_tick && !halt_exec |=> sys_tick) // RULE17
    else $error("undivided high tick missing");

endmodule

// *** core/wake_clk_map.svh ***
`ifndef WAKE_CLK_MAP_SVH
`define WAKE_CLK_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CLK_MODE_OFFSET 8'h00
`define CTRL_OFFSET 8'h04
`define STATUS_OFFSET 8'h08

// ----------------------------------------
// clock mode register fields
// ----------------------------------------
`define CKS_MSB 7
`define CKS_LSB 5
`define FAST_WAKE_ENABLE_BIT 4
`define LTO_BIT 3
`define HTO_BIT 2
`define IDLE_ON_HALT_ENABLE_BIT 1
`define HIGH_CLOCK_SELECT_BIT 0
`define CLK_MODE_RESET 8'h03

// ----------------------------------------
// control register fields
// ----------------------------------------
`define IDLE_SYSCLK_KEEP_BIT 7
`define CTRL_RESET 8'h00

// ----------------------------------------
// stabilisation counts, in oscillator cycles
// ----------------------------------------
`define HIGH_XTAL_CYCLES 128
`define HIGH_RC_CYCLES 16
`define LOW_XTAL_CYCLES 128
`define LOW_RC_CYCLES 2

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** core/wake_clk_pkg.sv ***
package wake_clk_pkg;

  typedef enum logic [7:0] {
    st_run_fast = 8'h01,
    st_run_slow = 8'h02,
    st_idle0 = 8'h04,
    st_idle1 = 8'h08,
    st_sleep0 = 8'h10,
    st_sleep1 = 8'h20,
    st_wake = 8'h40,
    st_fast_wake = 8'h80
  } pmode_t;

  typedef struct packed {
    pmode_t state;
    logic src_high;
    logic high_run;
    logic high_osc_ready_flag;
    logic low_osc_ready_flag;
    logic [7:0] hcnt;
    logic [7:0] lcnt;
    logic [5:0] div_cnt;
    logic [2:0] cks;
    logic fast_wake_enable;
    logic idle_on_halt_enable;
    logic high_clock_select;
    logic idle_sysclk_keep;
    logic sys_tick;
    logic div16_tick;
    logic div64_tick;
    logic cpu_run;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage

// *** verification/wakeup_and_clock_mode_switch_tb_top.sv ***
`timescale 1ns/100ps
`include "wake_clk_map.svh"
module wakeup_and_clock_mode_switch_tb_top;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic high_osc_tick, sub_osc_tick, high_is_crystal, low_is_crystal, watchdog_enable, lvd_enable;
  logic halt_exec, wake_event, sys_tick, cpu_run, high_osc_run, sub_osc_run, div16_tick, div64_tick;
  logic [1:0] tick_en;
  logic [1:0] sub_ph;
  logic [31:0] rnd;
  int n_mismatch, comparisons;
  logic [31:0] eq_data[$];
  logic [31:0] eq_mask[$];
  logic [1:0] eq_rresp[$];
  logic [1:0] eq_bresp[$];
  string eq_name[$];

  // small counts keep the run short
  wake_clk_ctrl #(.HIGH_XTAL_CYCLES(4), .HIGH_RC_CYCLES(2), .LOW_XTAL_CYCLES(4), .LOW_RC_CYCLES(1)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .high_osc_tick, .sub_osc_tick, .high_is_crystal, .low_is_crystal, .watchdog_enable, .lvd_enable,
    .halt_exec, .wake_event, .sys_tick, .cpu_run, .high_osc_run, .sub_osc_run, .div16_tick, .div64_tick);

  // ----------------------------------------
  // clock, oscillators, random source
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // oscillators only tick while the block enables them
  always @(posedge aclk)
  begin
    rnd <= xs(rnd);
    sub_ph <= sub_ph + 2'd1;
    high_osc_tick <= tick_en[1] & (high_osc_run === 1'b1) & rnd[0];
    sub_osc_tick <= tick_en[0] & (sub_osc_run === 1'b1) & (sub_ph == 2'd0);
  end

  // ----------------------------------------
  // comparison and reporting
  // ----------------------------------------
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmp_pin(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
    begin
      cmp_word(eq_name[0], eq_data.pop_front(), s_axi_rdata & eq_mask.pop_front());
      cmp_resp({eq_name.pop_front(), " rresp"}, eq_rresp.pop_front(), s_axi_rresp);
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      cmp_resp("bresp", eq_bresp.pop_front(), s_axi_bresp);
  end

  // ----------------------------------------
  // bus and sequence tasks
  // ----------------------------------------
  task step(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    eq_bresp.push_back(a > `STATUS_OFFSET ? `RESP_SLVERR : `RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {rnd[31:8], d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid === 1'b1)
        s_axi_bready <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    eq_data.push_back(e);
    eq_mask.push_back(m);
    eq_name.push_back(nm);
    eq_rresp.push_back(a > `STATUS_OFFSET ? `RESP_SLVERR : `RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid === 1'b1)
        s_axi_rready <= 1'b0;
    end
    while (s_axi_arvalid || s_axi_rready);
  endtask

  task cnt(input int n, output int s, output int c, output int d, output int h);
    s = 0;
    c = 0;
    d = 0;
    h = 0;
    repeat (n)
    begin
      @(posedge aclk);
      s += (sys_tick === 1'b1);
      c += (cpu_run === 1'b1);
      d += (div16_tick === 1'b1) || (div64_tick === 1'b1);
      h += (high_osc_tick === 1'b1);
    end
  endtask

  // halt into a power-down mode, wake with the high oscillator held still
  task pd(input logic fsy, input logic idl, input logic [1:0] lw, input logic xt, input logic fen,
    input logic [7:0] ep, input logic [7:0] ew);
    int s, c, d, h;
    high_is_crystal <= xt;
    {lvd_enable, watchdog_enable} <= lw;
    wr(`CTRL_OFFSET, {fsy, 7'h00});
    wr(`CLK_MODE_OFFSET, {3'b000, fen, 2'b00, idl, 1'b1});
    halt_exec <= 1'b1;
    @(posedge aclk);
    halt_exec <= 1'b0;
    step(4);
    rd(`STATUS_OFFSET, {24'h0, ep}, 32'hff, "power-down state");
    cnt(32, s, c, d, h);
    cmp_pin("idle system clock", ep == 8'h08, s > 0);
    cmp_pin("cpu halted", 1'b0, c > 0);
    tick_en <= 2'b01;
    wake_event <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
    step(3);
    rd(`STATUS_OFFSET, {24'h0, ew}, 32'hff, "wake state");
    cnt(8, s, c, d, h);
    cmp_pin("runs on sub clock", ew == 8'h80, c > 0);
    tick_en <= 2'b11;
    step(100);
    rd(`STATUS_OFFSET, 32'h01, 32'hff, "resumed fast");
    $display("test power-down %h done", ep);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    int s, c, d, h, dv;
    aresetn = 1'b0;
    rnd = 32'ha39c;
    sub_ph = 2'd0;
    tick_en = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {high_osc_tick, sub_osc_tick, halt_exec, wake_event, watchdog_enable, lvd_enable} = '0;
    high_is_crystal = 1'b1;
    low_is_crystal = 1'b1;
    step(10);
    aresetn <= 1'b1;
    rd(`CLK_MODE_OFFSET, 32'h03, 32'hffffffff, "mode reset");
    rd(`CTRL_OFFSET, 32'h00, 32'hffffffff, "control reset");
    rd(`STATUS_OFFSET, 32'h701, 32'hffffffff, "status reset");
    rd(8'h0c, 32'h00, 32'hffffffff, "unmapped read");
    wr(8'h0c, 8'hff);
    wr(`STATUS_OFFSET, 8'h02);
    rd(`STATUS_OFFSET, 32'h01, 32'hff, "status read only");
    tick_en <= 2'b11;
    step(100);
    rd(`CLK_MODE_OFFSET, 32'h0f, 32'hff, "ready flags");
    $display("test reset and flags done");
    for (int k = 7; k >= 0; k--)
    begin
      wr(`CLK_MODE_OFFSET, {k[2:0], 5'b00010});
      step(40);
      if (k < 2)
        rd(`STATUS_OFFSET, 32'h402, 32'h7ff, "slow source");
      else
      begin
        dv = 1 << (8 - k);
        cnt(32 * dv, s, c, d, h);
        cmp_pin("divider rate", 1'b1, s * dv >= h - 2 * dv && s * dv <= h + 2 * dv);
      end
    end
    rd(`CLK_MODE_OFFSET, 32'h08, 32'h08, "low ready in slow");
    cnt(64, s, c, d, h);
    cmp_pin("divided clocks stopped", 1'b0, d > 0);
    cmp_pin("high oscillator off", 1'b0, high_osc_run);
    tick_en <= 2'b01;
    wr(`CLK_MODE_OFFSET, 8'h03);
    step(20);
    rd(`STATUS_OFFSET, 32'h02, 32'hff, "waits for stable");
    tick_en <= 2'b11;
    step(100);
    rd(`STATUS_OFFSET, 32'h701, 32'h7ff, "fast again");
    $display("test mode switching done");
    pd(0, 1, 2'b00, 1, 0, 8'h04, 8'h40);
    pd(1, 1, 2'b00, 1, 0, 8'h08, 8'h40);
    pd(0, 0, 2'b01, 1, 0, 8'h20, 8'h40);
    pd(0, 0, 2'b00, 1, 1, 8'h10, 8'h40);
    pd(0, 0, 2'b01, 1, 1, 8'h20, 8'h80);
    pd(0, 0, 2'b10, 1, 1, 8'h20, 8'h80);
    pd(0, 1, 2'b00, 1, 1, 8'h04, 8'h80);
    pd(0, 0, 2'b01, 0, 1, 8'h20, 8'h40);
    summarize();
  end

  // generous bound, about five times the expected run
  initial
  begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end
endmodule
